// ---- sadc_pkg.sv ----
// Shared constants and types for the converter link and its host
package sadc_pkg;

  // Result word: sign bit then magnitude, MSB first
  localparam int RESULT_W = 15;
  localparam int BIT_CNT_W = 4;

  // Clock of both ends
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLK_FREQ_KHZ = 200000;

  // Strobe high width, least time rounded up
  localparam int STROBE_HIGH_PS = 28500;
  localparam int STROBE_HIGH_CYC =
    (STROBE_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Serial clock: full-rate figure, and the divider actually used
  localparam int SCK_FREQ_KHZ = 105000;
  localparam int SCK_HALF_RATE = CLK_FREQ_KHZ / (2 * SCK_FREQ_KHZ);
  // Round trip through both synchronisers needs this many cycles
  localparam int SYNC_TRIP_CYC = 8;
  localparam int SCK_HALF_CYC =
    (SCK_HALF_RATE > SYNC_TRIP_CYC) ? SCK_HALF_RATE : SYNC_TRIP_CYC;

  // Reinitialisation after supply return, and reference recharge
  localparam int POR_WAIT_MS = 10;
  localparam longint POR_WAIT_CYC_L =
    longint'(POR_WAIT_MS) * 64'h0000_0000_3b9a_ca00 / CLK_PERIOD_PS;
  localparam int POR_WAIT_CYC = int'(POR_WAIT_CYC_L);
  localparam int SLEEP_WAKE_MS = 10;
  localparam longint SLEEP_WAKE_CYC_L =
    longint'(SLEEP_WAKE_MS) * 64'h0000_0000_3b9a_ca00 / CLK_PERIOD_PS;
  localparam int SLEEP_WAKE_CYC = int'(SLEEP_WAKE_CYC_L);
  localparam int WAIT_W = 22;

  // Lone strobe counts that move the power state
  localparam int STRB_W = 3;
  localparam logic [STRB_W-1:0] STRB_TO_NAP = 3'h2;
  localparam logic [STRB_W-1:0] STRB_TO_SLEEP = 3'h4;
  localparam logic [STRB_W-1:0] STRB_TO_WAKE = 3'h5;

  typedef enum logic [1:0] {
    SADC_OPER = 2'b00,
    SADC_NAP = 2'b01,
    SADC_SLEEP = 2'b10
  } sadc_power_t;

endpackage

// ---- sadc_link_if.sv ----
// Serial link between the converter and its host controller
`timescale 1ns/1ps
interface sadc_link_if;
  logic conversion_strobe_n;
  logic sck_pos;
  logic sck_neg;
  logic lvds_sel;
  logic serial_out_pos;
  logic serial_out_neg;

  modport dev (
    input conversion_strobe_n,
    input sck_pos,
    input sck_neg,
    input lvds_sel,
    output serial_out_pos,
    output serial_out_neg
  );

  modport host (
    output conversion_strobe_n,
    output sck_pos,
    output sck_neg,
    output lvds_sel,
    input serial_out_pos,
    input serial_out_neg
  );
endinterface

// ---- sadc_device.sv ----
// Converter end: strobe and serial clock decode, readout, power modes
// Functional notes
// - First result after idling is stale; host discards.
// - Reset on power-up or low supply.
// - Host waits 10ms after reset before converting.
// - Strobe rise samples, fall starts conversion and readout.
// - Conversion completes at strobe fall; readout is paced by the host serial clock.
// - Host strobe high width about 28.5ns.
// - Next bit out on each clock fall, MSB first.
// - Host runs serial clock at 12.5MHz (8-cycle half period), not the 105MHz full-rate figure.
// - Two strobes, clock idle, enter nap.
// - Clock rising edge wakes from nap.
// - Two more strobes in nap enter sleep.
// - CMOS mode: clock rising edge wakes from sleep.
// - Host waits 10ms after sleep wake.
// - Fifth strobe wakes from sleep, both modes.
// - Clock pulses keep device out of nap.
// - Strobes alone cycle operational, nap, sleep forever.
// - Select input picks CMOS or LVDS.
// - CMOS uses positive pins; negative pins idle low.
// - LVDS drives data and takes clock differentially.
`timescale 1ns/1ps
module sadc_device #(
  parameter int REINIT_CYC = sadc_pkg::POR_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  sadc_link_if.dev link,
  input wire logic supply_ok,
  input wire logic [sadc_pkg::RESULT_W-1:0] analog_code,
  output sadc_pkg::sadc_power_t power_state,
  output logic reinit_busy
);

  localparam int SYNC_N = 5;
  localparam int W = sadc_pkg::RESULT_W;

  // Pin synchronisers; only stage two is read by logic
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] sync1_ff;
  logic [SYNC_N-1:0] sync2_ff;

  assign pin_raw = {supply_ok, link.lvds_sel, link.sck_neg,
                    link.sck_pos, link.conversion_strobe_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic strobe_s;
  logic sck_pos_s;
  logic sck_neg_s;
  logic lvds_s;
  logic supply_s;
  logic sck_s;

  assign strobe_s = sync2_ff[0];
  assign sck_pos_s = sync2_ff[1];
  assign sck_neg_s = sync2_ff[2];
  assign lvds_s = sync2_ff[3];
  assign supply_s = sync2_ff[4];
  // Differential clock counts high only when the pair is split
  assign sck_s = lvds_s ? (sck_pos_s & ~sck_neg_s) : sck_pos_s;

  // Edge detection on synchronised strobe and clock
  logic strobe_prev_ff;
  logic sck_prev_ff;
  logic strobe_rise;
  logic strobe_fall;
  logic sck_rise;
  logic sck_fall;

  assign strobe_rise = strobe_s & ~strobe_prev_ff;
  assign strobe_fall = ~strobe_s & strobe_prev_ff;
  assign sck_rise = sck_s & ~sck_prev_ff;
  assign sck_fall = ~sck_s & sck_prev_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_prev_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
    end else begin
      strobe_prev_ff <= strobe_s;
      sck_prev_ff <= sck_s;
    end
  end

  // Core state
  sadc_pkg::sadc_power_t pwr_ff;
  sadc_pkg::sadc_power_t nxt_pwr;
  logic [sadc_pkg::STRB_W-1:0] strb_ff;
  logic [sadc_pkg::STRB_W-1:0] nxt_strb;
  logic [sadc_pkg::WAIT_W-1:0] reinit_ff;
  logic [sadc_pkg::WAIT_W-1:0] nxt_reinit;
  logic [W-1:0] sample_ff;
  logic [W-1:0] nxt_sample;
  logic [W-1:0] result_ff;
  logic [W-1:0] nxt_result;
  logic [W-1:0] shift_ff;
  logic [W-1:0] nxt_shift;
  logic [sadc_pkg::BIT_CNT_W-1:0] bits_ff;
  logic [sadc_pkg::BIT_CNT_W-1:0] nxt_bits;
  logic out_pos_ff;
  logic nxt_out_pos;
  logic out_neg_ff;
  logic nxt_out_neg;
  logic busy_ff;
  logic nxt_busy;
  logic [sadc_pkg::STRB_W-1:0] strb_inc;
  logic clk_wakes;

  assign strb_inc = strb_ff + 3'h1;
  // LVDS sleep ignores the clock, so lone strobes keep counting there
  assign clk_wakes = !(pwr_ff == sadc_pkg::SADC_SLEEP && lvds_s);

  // Next-state logic for power modes, sampling and readout
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_strb = strb_ff;
    nxt_reinit = reinit_ff;
    nxt_sample = sample_ff;
    nxt_result = result_ff;
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    if (!supply_s) begin
      // Low supply holds everything cleared and rearms the wait
      nxt_pwr = sadc_pkg::SADC_OPER;
      nxt_strb = 3'h0;
      nxt_reinit = sadc_pkg::WAIT_W'(REINIT_CYC);
      nxt_sample = '0;
      nxt_result = '0;
      nxt_shift = '0;
      nxt_bits = '0;
    end else begin
      if (reinit_ff != '0) begin
        nxt_reinit = reinit_ff - 22'h00_0001;
      end
      // Clock rise wakes and clears the lone strobe count
      if (sck_rise && clk_wakes) begin
        nxt_strb = 3'h0;
        unique case (pwr_ff)
          sadc_pkg::SADC_OPER: nxt_pwr = sadc_pkg::SADC_OPER;
          sadc_pkg::SADC_NAP: nxt_pwr = sadc_pkg::SADC_OPER;
          sadc_pkg::SADC_SLEEP: nxt_pwr = sadc_pkg::SADC_OPER;
          default: nxt_pwr = sadc_pkg::SADC_OPER;
        endcase
      end else if (strobe_rise) begin
        nxt_strb = strb_inc;
        if (strb_inc == sadc_pkg::STRB_TO_NAP) begin
          nxt_pwr = sadc_pkg::SADC_NAP;
          // Stale result makes the first word of a burst invalid
          nxt_result = '0;
        end else if (strb_inc == sadc_pkg::STRB_TO_SLEEP) begin
          nxt_pwr = sadc_pkg::SADC_SLEEP;
        end else if (strb_inc == sadc_pkg::STRB_TO_WAKE) begin
          nxt_pwr = sadc_pkg::SADC_OPER;
          nxt_strb = 3'h0;
        end
      end
      // Rising strobe takes the sample while awake and settled
      if (strobe_rise && pwr_ff == sadc_pkg::SADC_OPER
          && reinit_ff == '0) begin
        nxt_sample = analog_code;
      end
      // Falling strobe converts; readout carries the previous result
      if (strobe_fall && pwr_ff == sadc_pkg::SADC_OPER) begin
        nxt_shift = result_ff;
        nxt_result = sample_ff;
        nxt_bits = sadc_pkg::BIT_CNT_W'(W - 1);
      end else if (sck_fall && bits_ff != '0) begin
        // Each clock fall moves the next bit up
        nxt_shift = {shift_ff[W-2:0], 1'b0};
        nxt_bits = bits_ff - 4'h1;
      end
    end
    nxt_busy = (nxt_reinit != '0);
    nxt_out_pos = nxt_shift[W-1];
    // Negative pin idles low outside LVDS, like its pull-down
    nxt_out_neg = lvds_s ? ~nxt_shift[W-1] : 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_ff <= sadc_pkg::SADC_OPER;
      strb_ff <= 3'h0;
      reinit_ff <= 22'h00_0000;
      sample_ff <= '0;
      result_ff <= '0;
      shift_ff <= '0;
      bits_ff <= 4'h0;
      out_pos_ff <= 1'b0;
      out_neg_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      pwr_ff <= nxt_pwr;
      strb_ff <= nxt_strb;
      reinit_ff <= nxt_reinit;
      sample_ff <= nxt_sample;
      result_ff <= nxt_result;
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
      out_pos_ff <= nxt_out_pos;
      out_neg_ff <= nxt_out_neg;
      busy_ff <= nxt_busy;
    end
  end

  // Outputs straight from flops
  assign link.serial_out_pos = out_pos_ff;
  assign link.serial_out_neg = out_neg_ff;
  assign power_state = pwr_ff;
  assign reinit_busy = busy_ff;

endmodule // sadc_device

// ---- sadc_host.sv ----
// Host end: strobe and serial clock generation, word capture
`timescale 1ns/1ps
module sadc_host #(
  parameter int SETTLE_CYC = sadc_pkg::POR_WAIT_CYC,
  parameter int WAKE_CYC = sadc_pkg::SLEEP_WAKE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  sadc_link_if.host link,
  input wire logic lvds_mode,
  input wire logic conv_req,
  input wire logic pulse_req,
  input wire logic wake_req,
  output logic ready,
  output logic [sadc_pkg::RESULT_W-1:0] word,
  output logic word_valid,
  output logic word_discard,
  output logic [sadc_pkg::STRB_W-1:0] lone_count
);

  localparam int W = sadc_pkg::RESULT_W;
  localparam int CW = sadc_pkg::WAIT_W;

  typedef enum logic [2:0] {
    H_WAIT = 3'b000,
    H_IDLE = 3'b001,
    H_STRB_HI = 3'b010,
    H_SCK_LO = 3'b011,
    H_SCK_HI = 3'b100,
    H_WAKE = 3'b101,
    H_GAP = 3'b110
  } sadc_hstate_t;

  // Data pin synchroniser; stage two only is read
  logic din_s1_ff;
  logic din_s2_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      din_s1_ff <= link.serial_out_pos;
      din_s2_ff <= din_s1_ff;
    end
  end

  sadc_hstate_t st_ff;
  sadc_hstate_t nxt_st;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [sadc_pkg::BIT_CNT_W-1:0] bits_ff;
  logic [sadc_pkg::BIT_CNT_W-1:0] nxt_bits;
  logic [sadc_pkg::STRB_W-1:0] strb_ff;
  logic [sadc_pkg::STRB_W-1:0] nxt_strb;
  logic [W-1:0] word_ff;
  logic [W-1:0] nxt_word;
  logic lone_ff, nxt_lone;
  logic first_ff, nxt_first;
  logic strobe_ff, nxt_strobe;
  logic sck_neg_ff, nxt_sck_neg;
  logic sck_ff, nxt_sck;
  logic valid_ff, nxt_valid;
  logic disc_ff, nxt_disc;
  logic ready_ff, nxt_ready;
  logic lvds_ff;
  logic [sadc_pkg::STRB_W-1:0] strb_inc;

  assign strb_inc = strb_ff + 3'h1;

  // Sequencer for strobes, clock bursts and waits
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_bits = bits_ff;
    nxt_strb = strb_ff;
    nxt_word = word_ff;
    nxt_lone = lone_ff;
    nxt_first = first_ff;
    nxt_strobe = strobe_ff;
    nxt_sck = sck_ff;
    nxt_valid = 1'b0;
    nxt_disc = disc_ff;
    unique case (st_ff)
      H_WAIT: begin
        if (cnt_ff == '0) begin
          nxt_st = H_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 22'h00_0001;
        end
      end
      H_IDLE: begin
        // Conversions only while awake; lone pulses always allowed
        if (conv_req && strb_ff < sadc_pkg::STRB_TO_NAP) begin
          nxt_strobe = 1'b1;
          nxt_lone = 1'b0;
          nxt_cnt = CW'(sadc_pkg::STROBE_HIGH_CYC - 1);
          nxt_st = H_STRB_HI;
        end else if (pulse_req) begin
          nxt_strobe = 1'b1;
          nxt_lone = 1'b1;
          nxt_cnt = CW'(sadc_pkg::STROBE_HIGH_CYC - 1);
          nxt_st = H_STRB_HI;
        end else if (wake_req && !(lvds_ff
                     && strb_ff >= sadc_pkg::STRB_TO_SLEEP)) begin
          nxt_sck = 1'b1;
          nxt_cnt = CW'(sadc_pkg::SCK_HALF_CYC - 1);
          nxt_st = H_WAKE;
        end
      end
      H_STRB_HI: begin
        if (cnt_ff == '0) begin
          nxt_strobe = 1'b0;
          nxt_cnt = CW'(sadc_pkg::SCK_HALF_CYC - 1);
          nxt_bits = sadc_pkg::BIT_CNT_W'(W);
          if (lone_ff) begin
            // Clock stays still, so the device counts this strobe
            nxt_st = H_GAP;
            nxt_strb = strb_inc;
            if (strb_inc == sadc_pkg::STRB_TO_NAP) begin
              nxt_first = 1'b1;
            end
            if (strb_inc == sadc_pkg::STRB_TO_WAKE) begin
              nxt_strb = 3'h0;
              nxt_cnt = CW'(WAKE_CYC);
              nxt_st = H_WAIT;
            end
          end else begin
            nxt_st = H_SCK_LO;
          end
        end else begin
          nxt_cnt = cnt_ff - 22'h00_0001;
        end
      end
      H_SCK_LO: begin
        if (cnt_ff == '0) begin
          nxt_sck = 1'b1;
          nxt_strb = 3'h0;
          nxt_cnt = CW'(sadc_pkg::SCK_HALF_CYC - 1);
          nxt_st = H_SCK_HI;
        end else begin
          nxt_cnt = cnt_ff - 22'h00_0001;
        end
      end
      H_SCK_HI: begin
        if (cnt_ff == '0) begin
          // Sample late in the high phase, after the bit settled
          nxt_word = {word_ff[W-2:0], din_s2_ff};
          nxt_sck = 1'b0;
          nxt_bits = bits_ff - 4'h1;
          nxt_cnt = CW'(sadc_pkg::SCK_HALF_CYC - 1);
          if (bits_ff == 4'h1) begin
            nxt_valid = 1'b1;
            nxt_disc = first_ff;
            nxt_first = 1'b0;
            nxt_st = H_GAP;
          end else begin
            nxt_st = H_SCK_LO;
          end
        end else begin
          nxt_cnt = cnt_ff - 22'h00_0001;
        end
      end
      H_WAKE: begin
        if (cnt_ff == '0) begin
          nxt_sck = 1'b0;
          nxt_strb = 3'h0;
          if (strb_ff >= sadc_pkg::STRB_TO_SLEEP) begin
            nxt_cnt = CW'(WAKE_CYC);
            nxt_st = H_WAIT;
          end else begin
            nxt_cnt = CW'(sadc_pkg::SCK_HALF_CYC - 1);
            nxt_st = H_GAP;
          end
        end else begin
          nxt_cnt = cnt_ff - 22'h00_0001;
        end
      end
      H_GAP: begin
        if (cnt_ff == '0) begin
          nxt_st = H_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 22'h00_0001;
        end
      end
      default: nxt_st = H_WAIT;
    endcase
    nxt_ready = (nxt_st == H_IDLE);
    // Negative clock pin registered so it cannot glitch
    nxt_sck_neg = lvds_mode & ~nxt_sck;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= H_WAIT;
      cnt_ff <= CW'(SETTLE_CYC);
      bits_ff <= 4'h0;
      strb_ff <= 3'h0;
      word_ff <= '0;
      lone_ff <= 1'b0;
      first_ff <= 1'b1;
      strobe_ff <= 1'b0;
      sck_neg_ff <= 1'b0;
      sck_ff <= 1'b0;
      valid_ff <= 1'b0;
      disc_ff <= 1'b0;
      ready_ff <= 1'b0;
      lvds_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      bits_ff <= nxt_bits;
      strb_ff <= nxt_strb;
      word_ff <= nxt_word;
      lone_ff <= nxt_lone;
      first_ff <= nxt_first;
      strobe_ff <= nxt_strobe;
      sck_neg_ff <= nxt_sck_neg;
      sck_ff <= nxt_sck;
      valid_ff <= nxt_valid;
      disc_ff <= nxt_disc;
      ready_ff <= nxt_ready;
      lvds_ff <= lvds_mode;
    end
  end

  // Pins from flops; clock pair split only in LVDS
  assign link.conversion_strobe_n = strobe_ff;
  assign link.sck_pos = sck_ff;
  assign link.sck_neg = sck_neg_ff;
  assign link.lvds_sel = lvds_ff;
  assign ready = ready_ff;
  assign word = word_ff;
  assign word_valid = valid_ff;
  assign word_discard = disc_ff;
  assign lone_count = strb_ff;

endmodule // sadc_host

// ---- sadc_link_props.sv ----
// Link assertions for the converter and host ends
`timescale 1ns/1ps
module sadc_link_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conversion_strobe_n,
  input wire logic sck_pos,
  input wire logic sck_neg,
  input wire logic lvds_sel,
  input wire logic serial_out_pos,
  input wire logic serial_out_neg
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Strobe shape and its spacing from the serial clock
  strobe_width_a: assert property (
    $rose(conversion_strobe_n) |-> conversion_strobe_n [*6])
    else $error("strobe high phase too short");
  strobe_quiet_a: assert property (
    conversion_strobe_n |-> !sck_pos)
    else $error("serial clock high during sampling phase");
  conv_lead_a: assert property (
    $fell(conversion_strobe_n) |-> !sck_pos [*8])
    else $error("serial clock rose too soon after strobe fall");
  clk_half_a: assert property (
    $rose(sck_pos) |-> sck_pos [*8] ##1 !sck_pos)
    else $error("serial clock high phase not eight cycles");

  // Pin pairs; the data pair's past term lets the device's synchroniser catch up
  data_pair_a: assert property (
    lvds_sel && $past(lvds_sel, 4) |-> serial_out_neg != serial_out_pos)
    else $error("data pair not complementary");
  data_neg_idle_a: assert property (
    !lvds_sel && !$past(lvds_sel, 4) |-> !serial_out_neg)
    else $error("negative data pin not low");
  clk_pair_a: assert property (
    lvds_sel && $past(lvds_sel) |-> sck_neg != sck_pos)
    else $error("clock pair not complementary");
  clk_neg_idle_a: assert property (
    !lvds_sel && !$past(lvds_sel) |-> !sck_neg)
    else $error("negative clock pin not low");
endmodule // sadc_link_props

// ---- tb_sar_adc_serial_readout_power_modes.sv ----
// Testbench joining converter and host ends over the serial link
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  errors++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb_sar_adc_serial_readout_power_modes;
  localparam int SETTLE = 50;
  localparam int REINIT = 50;
  localparam int WAKE = 50;
  logic clk, reset_n, supply_ok, lvds_mode, conv_req, pulse_req, wake_req;
  logic ready, word_valid, word_discard, reinit_busy, prev_sck, prev_strobe;
  logic [sadc_pkg::RESULT_W-1:0] analog_code, word, wire_bits;
  logic [sadc_pkg::STRB_W-1:0] lone_count;
  logic [sadc_pkg::STRB_W-1:0] exp_cnt [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  sadc_pkg::sadc_power_t power_state;
  sadc_pkg::sadc_power_t exp_st [5] = '{sadc_pkg::SADC_OPER,
    sadc_pkg::SADC_NAP, sadc_pkg::SADC_NAP, sadc_pkg::SADC_SLEEP,
    sadc_pkg::SADC_OPER};
  int errors, check_count, n;

  sadc_link_if link ();

  // Short waits keep the run brief; expectations use the same values
  sadc_device #(.REINIT_CYC(REINIT)) sadc_device_inst (.clk(clk),
    .reset_n(reset_n), .link(link), .supply_ok(supply_ok),
    .analog_code(analog_code), .power_state(power_state),
    .reinit_busy(reinit_busy));
  sadc_host #(.SETTLE_CYC(SETTLE), .WAKE_CYC(WAKE)) sadc_host_inst (
    .clk(clk), .reset_n(reset_n), .link(link), .lvds_mode(lvds_mode),
    .conv_req(conv_req), .pulse_req(pulse_req), .wake_req(wake_req),
    .ready(ready), .word(word), .word_valid(word_valid),
    .word_discard(word_discard), .lone_count(lone_count));
  sadc_link_props sadc_link_props_inst (.clk(clk), .reset_n(reset_n),
    .conversion_strobe_n(link.conversion_strobe_n),
    .sck_pos(link.sck_pos), .sck_neg(link.sck_neg),
    .lvds_sel(link.lvds_sel), .serial_out_pos(link.serial_out_pos),
    .serial_out_neg(link.serial_out_neg));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Wire monitor: bits as seen on each serial clock rise
  always @(posedge clk) begin
    prev_sck <= link.sck_pos;
    prev_strobe <= link.conversion_strobe_n;
    if (prev_strobe && !link.conversion_strobe_n) wire_bits <= '0;
    else if (!prev_sck && link.sck_pos)
      wire_bits <= {wire_bits[13:0], link.serial_out_pos};
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Bounded wait; a hang here shows as a mismatch, not a stall
  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1 && k < 2000) begin
      tick();
      k++;
    end
    if (k == 2000) begin
      errors++;
      $display("[FAIL] ready exp 1 got %b", ready);
    end
  endtask

  // Request held for the one edge at which ready is high
  task automatic req(input int which);
    wait_ready();
    conv_req = (which == 0);
    pulse_req = (which == 1);
    wake_req = (which == 2);
    tick();
    conv_req = 1'b0;
    pulse_req = 1'b0;
    wake_req = 1'b0;
  endtask

  // Lone strobe or wake pulse, then let the power state settle
  task automatic step(input int which);
    req(which);
    wait_ready();
    repeat (6) tick();
  endtask

  task automatic conv(input logic [14:0] ex_w, input logic ex_d);
    int k;
    k = 0;
    req(0);
    while (word_valid !== 1'b1 && k < 1000) begin
      tick();
      k++;
    end
    if (k == 1000) begin
      errors++;
      $display("[FAIL] word_valid exp 1 got %b", word_valid);
    end
    `CHK("word", ex_w, word)
    `CHK("discard", ex_d, word_discard)
    `CHK("wire bits", ex_w, wire_bits)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {reset_n, conv_req, pulse_req, wake_req, lvds_mode} = '0;
    supply_ok = 1'b1;
    analog_code = 15'h4a3c;
    errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
    `CHK("settle wait", 1'b1, n >= SETTLE)
    conv(15'h0000, 1'b1);
    analog_code = 15'h2c71;
    conv(15'h4a3c, 1'b0);
    conv(15'h2c71, 1'b0);
    // Clock between lone strobes clears their count; a conversion
    // strobe right after a lone one would count as the second
    step(1);
    step(2);
    `CHK("lone count", 3'h0, lone_count)
    conv(15'h2c71, 1'b0);
    step(1);
    `CHK("lone count", 3'h1, lone_count)
    `CHK("state", sadc_pkg::SADC_OPER, power_state)
    step(2);
    // Strobes alone cycle the states, in both signalling modes
    for (int m = 0; m < 2; m++) begin
      lvds_mode = m[0];
      repeat (8) tick();
      for (int i = 0; i < 5; i++) begin
        step(1);
        `CHK("state", exp_st[i], power_state)
        `CHK("lone count", exp_cnt[i], lone_count)
        if (m == 1 && i == 3) begin
          step(2);
          `CHK("lvds sleep", sadc_pkg::SADC_SLEEP, power_state)
        end
      end
    end
    // CMOS wake from sleep and from nap by one clock rise
    lvds_mode = 1'b0;
    repeat (8) tick();
    repeat (4) step(1);
    `CHK("state", sadc_pkg::SADC_SLEEP, power_state)
    // Host must hold off for the recharge time after a sleep wake
    req(2);
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      tick();
      n++;
    end
    `CHK("sleep wake wait", 1'b1, n >= WAKE)
    repeat (6) tick();
    `CHK("state", sadc_pkg::SADC_OPER, power_state)
    `CHK("lone count", 3'h0, lone_count)
    step(1);
    step(1);
    `CHK("state", sadc_pkg::SADC_NAP, power_state)
    step(2);
    `CHK("state", sadc_pkg::SADC_OPER, power_state)
    conv(15'h0000, 1'b1);
    lvds_mode = 1'b1;
    repeat (8) tick();
    conv(15'h2c71, 1'b0);
    // Supply dip from nap forces a reinitialisation back to operation
    step(1);
    step(1);
    `CHK("state", sadc_pkg::SADC_NAP, power_state)
    supply_ok = 1'b0;
    repeat (10) tick();
    `CHK("reinit", 1'b1, reinit_busy)
    supply_ok = 1'b1;
    n = 0;
    while (reinit_busy !== 1'b0 && n < 500) begin
      tick();
      n++;
    end
    `CHK("reinit", 1'b0, reinit_busy)
    `CHK("reinit length", 1'b1, n >= REINIT)
    `CHK("state", sadc_pkg::SADC_OPER, power_state)
    tally_and_finish();
  end
endmodule // tb_sar_adc_serial_readout_power_modes
